// File: rtl/quad_dac_twowire_slave_port.sv
// Operation
// - Works at standard, fast and high-speed rates.
// - Only 7-bit addresses; ten-bit and general call never acknowledged.
// - Start is data falling while clock high, detected anytime.
// - Transmitter keeps data stable while clock high.
// - Acknowledge own address by holding data low through ninth clock.
// - Receiver acknowledges every data byte.
// - Units of eight data bits plus acknowledge repeat until stop.
// - Stop is data rising while clock high; ends the link.
// - After stop, release lines and ignore traffic until matching start.
// - Data line only pulled low or released.
// - Channel codes are unsigned binary 0 to 255.
// - Reject spikes below 50 ns fast, 10 ns high-speed; the high-speed filter length is one sample, so any sampled spike passes.
// - Master code 00001xxx enters high-speed; stop leaves it.
// - Address is 10011 then both select pins captured at power-up.
`timescale 1ns/1ps
`include "twowire_slave_map.svh"
`default_nettype none

// ============================================================
// Spike filter
module twowire_glitch_filter (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic raw,
  input wire logic [2:0] len,
  output logic level
);
  import twowire_slave_pkg::*;
  filt_state_t q;
  filt_state_t d;

  // Level follows only after len agreeing samples
  always_comb begin
    d = q;
    if (raw == q.level) begin
      d.cnt = 3'h0;
    end else if (q.cnt + 3'h1 >= len) begin
      d.level = raw;
      d.cnt = 3'h0;
    end else begin
      d.cnt = q.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{level: 1'b1, cnt: 3'h0};
    end else begin
      q <= d;
    end
  end

  assign level = q.level;

  property p_reject;
    @(posedge clk) disable iff (!rst_b)
      $changed(q.level) |-> $past(q.cnt) + 3'h1 >= $past(len);
  endproperty
  a_reject: assert property (p_reject)
    else $error("filter level moved before spike limit");
endmodule : twowire_glitch_filter

// ============================================================
// Bus-facing protocol engine on the sampling clock
module twowire_link_engine (
  input wire logic bus_clk,
  input wire logic rst_b,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic address_select_hi_pin,
  input wire logic address_select_lo_pin,
  output logic sda_oe,
  output logic [8:0] word,
  output logic tog,
  output logic act,
  output logic hs
);
  import twowire_slave_pkg::*;
  localparam int FS_RAW =
    (`SPIKE_FS_NS + `LINK_CLK_PERIOD_NS - 1) / `LINK_CLK_PERIOD_NS;
  localparam int HS_RAW =
    (`SPIKE_HS_NS + `LINK_CLK_PERIOD_NS - 1) / `LINK_CLK_PERIOD_NS;
  localparam logic [2:0] FS_CYC = 3'(FS_RAW < 1 ? 1 : FS_RAW);
  localparam logic [2:0] HS_CYC = 3'(HS_RAW < 1 ? 1 : HS_RAW);

  link_regs_t q;
  link_regs_t d;
  logic [1:0] lrst_q;
  logic lrst_b;
  logic scl_f;
  logic sda_f;
  logic [2:0] flen;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic addr_match;

  // Release of reset is synchronised so all link flops leave it together
  always_ff @(posedge bus_clk or negedge rst_b) begin
    if (!rst_b) begin
      lrst_q <= 2'h0;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end
  assign lrst_b = lrst_q[1];

  // Filter window shrinks in high-speed so fast pulses survive
  assign flen = q.hs ? HS_CYC : FS_CYC;

  twowire_glitch_filter u_scl_filt (
    .clk(bus_clk),
    .rst_b(lrst_b),
    .raw(q.scl_s[1]),
    .len(flen),
    .level(scl_f)
  );
  twowire_glitch_filter u_sda_filt (
    .clk(bus_clk),
    .rst_b(lrst_b),
    .raw(q.sda_s[1]),
    .len(flen),
    .level(sda_f)
  );

  // ============================================================
  // Bus events
  assign scl_rise = scl_f & ~q.scl_p;
  assign scl_fall = ~scl_f & q.scl_p;
  assign start = scl_f & q.scl_p & q.sda_p & ~sda_f;
  assign stop = scl_f & q.scl_p & ~q.sda_p & sda_f;
  assign addr_match = q.sh[7:1] == {`DEV_ADDR_HI, q.sel};

  // ============================================================
  // Protocol state machine
  always_comb begin
    d = q;
    d.scl_s = {q.scl_s[0], scl_i};
    d.sda_s = {q.sda_s[0], sda_i};
    d.hi_s = {q.hi_s[0], address_select_hi_pin};
    d.lo_s = {q.lo_s[0], address_select_lo_pin};
    d.scl_p = scl_f;
    d.sda_p = sda_f;
    // Select pins track only until settled, then stay frozen
    if (q.strap_cnt != `STRAP_SETTLE) begin
      d.strap_cnt = q.strap_cnt + 2'h1;
      d.sel = {q.hi_s[1], q.lo_s[1]};
    end
    if (stop) begin
      d.st = ST_IDLE;
      d.oe = 1'b0;
      d.hs = 1'b0;
    end else if (start) begin
      // Repeated start keeps the speed setting
      d.st = ST_ADDR;
      d.cnt = 4'h0;
      d.oe = 1'b0;
    end else begin
      case (q.st)
        ST_ADDR, ST_WRITE: begin
          if (scl_rise) begin
            d.sh = {q.sh[6:0], sda_f};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == `BYTE_BITS) begin
            if (q.st == ST_WRITE) begin
              d.st = ST_WRITE_ACK;
              d.oe = 1'b1;
              d.last = q.sh;
              d.word = {q.first, q.sh};
              d.first = 1'b0;
              d.tog = ~q.tog;
            end else if (q.sh[7:3] == `HS_CODE_HI) begin
              d.hs = 1'b1;
              d.st = ST_IGNORE;
            end else if (addr_match) begin
              d.st = ST_ADDR_ACK;
              d.oe = 1'b1;
              d.rw = q.sh[0];
            end else begin
              // Ten-bit and general call never match
              d.st = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            d.cnt = 4'h0;
            d.first = 1'b1;
            if (q.rw) begin
              d.st = ST_READ;
              d.sh = q.last;
              d.oe = ~q.last[7];
            end else begin
              d.st = ST_WRITE;
              d.oe = 1'b0;
            end
          end
        end
        ST_WRITE_ACK: begin
          if (scl_fall) begin
            d.st = ST_WRITE;
            d.oe = 1'b0;
            d.cnt = 4'h0;
          end
        end
        ST_READ: begin
          if (scl_rise) begin
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall) begin
            if (q.cnt == `BYTE_BITS) begin
              d.st = ST_READ_ACK;
              d.oe = 1'b0;
            end else begin
              // Next bit changes only while clock is low
              d.sh = {q.sh[6:0], 1'b0};
              d.oe = ~q.sh[6];
            end
          end
        end
        ST_READ_ACK: begin
          if (scl_rise) begin
            d.acked = ~sda_f;
          end else if (scl_fall) begin
            d.cnt = 4'h0;
            if (q.acked) begin
              d.st = ST_READ;
              d.sh = q.last;
              d.oe = ~q.last[7];
            end else begin
              // Master refused the byte; wait for stop or start
              d.st = ST_IGNORE;
            end
          end
        end
        ST_IDLE, ST_IGNORE: begin
          d.oe = 1'b0;
        end
        default: begin
          d.st = ST_IDLE;
          d.oe = 1'b0;
        end
      endcase
    end
    d.act = d.st != ST_IDLE && d.st != ST_IGNORE;
  end

  always_ff @(posedge bus_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      q <= '{scl_s: 2'h3, sda_s: 2'h3, scl_p: 1'b1, sda_p: 1'b1,
             st: ST_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  // Device never drives the clock and only ever pulls data low
  assign sda_oe = q.oe;
  assign word = q.word;
  assign tog = q.tog;
  assign act = q.act;
  assign hs = q.hs;

  // ============================================================
  // Checks
  default clocking cb @(posedge bus_clk);
  endclocking
  default disable iff (!lrst_b);

  sequence s_addr_done;
    q.st == ST_ADDR && q.cnt == `BYTE_BITS && scl_fall;
  endsequence
  sequence s_ack_phase;
    sda_oe && q.st == ST_ADDR_ACK;
  endsequence

  property p_ack_match;
    s_addr_done and (addr_match && q.sh[7:3] != `HS_CODE_HI)
      |=> s_ack_phase;
  endproperty
  a_ack_match: assert property (p_ack_match)
    else $error("matching address not acknowledged");

  property p_ack_hold;
    s_ack_phase and (!scl_fall && !start && !stop) |=> sda_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("address acknowledge dropped early");

  property p_no_match;
    s_addr_done and !addr_match |=> !sda_oe && q.st == ST_IGNORE;
  endproperty
  a_no_match: assert property (p_no_match)
    else $error("foreign address acknowledged");

  property p_start;
    start |=> q.st == ST_ADDR && !sda_oe && q.cnt == 4'h0;
  endproperty
  a_start: assert property (p_start)
    else $error("start not taken");

  property p_stop;
    stop |=> q.st == ST_IDLE && !q.hs && !sda_oe ##1 !act;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not free the link");

  property p_hs;
    s_addr_done and q.sh[7:3] == `HS_CODE_HI |=> q.hs && !sda_oe;
  endproperty
  a_hs: assert property (p_hs)
    else $error("master code mishandled");

  property p_oe_low_scl;
    $rose(sda_oe) |-> !scl_f;
  endproperty
  a_oe_low_scl: assert property (p_oe_low_scl)
    else $error("data line changed while clock high");

  property p_wr_ack;
    q.st == ST_WRITE && q.cnt == `BYTE_BITS && scl_fall
      |=> sda_oe && tog != $past(tog) && word[7:0] == $past(q.sh);
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("data byte not acknowledged or passed on");

  property p_released;
    q.st inside {ST_IDLE, ST_IGNORE, ST_ADDR, ST_WRITE} |-> !sda_oe;
  endproperty
  a_released: assert property (p_released)
    else $error("data line held when it should be free");
endmodule : twowire_link_engine

// ============================================================
// Top: core-side delivery of received codes
module quad_dac_twowire_slave_port (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic bus_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic address_select_hi_pin,
  input wire logic address_select_lo_pin,
  output logic [7:0] rx_code,
  output logic rx_valid,
  output logic rx_first,
  output logic link_active,
  output logic hs_mode
);
  import twowire_slave_pkg::*;
  core_regs_t q;
  core_regs_t d;
  logic [8:0] link_word;
  logic link_tog;
  logic link_act;
  logic link_hs;

  twowire_link_engine u_link (
    .bus_clk(bus_clk),
    .rst_b(rst_b),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .address_select_hi_pin(address_select_hi_pin),
    .address_select_lo_pin(address_select_lo_pin),
    .sda_oe(sda_oe),
    .word(link_word),
    .tog(link_tog),
    .act(link_act),
    .hs(link_hs)
  );

  // Open drain: only ever a low level when enabled
  assign sda_o = 1'b0;

  // Word is held for a whole byte time after the toggle, so it is
  // stable long before the synchronised toggle edge samples it
  always_comb begin
    d = q;
    d.tog_s = {q.tog_s[1:0], link_tog};
    d.act_s = {q.act_s[2], link_hs, q.act_s[0], link_act};
    d.valid = q.tog_s[2] ^ q.tog_s[1];
    if (q.tog_s[2] ^ q.tog_s[1]) begin
      d.code = link_word[7:0];
      d.first = link_word[8];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rx_code = q.code;
  assign rx_valid = q.valid;
  assign rx_first = q.first;
  assign link_active = q.act_s[1];
  assign hs_mode = q.act_s[3];
endmodule : quad_dac_twowire_slave_port
`default_nettype wire

// File: rtl/twowire_slave_map.svh
`ifndef TWOWIRE_SLAVE_MAP_SVH
`define TWOWIRE_SLAVE_MAP_SVH
// Fixed upper address bits, then the two select pins
`define DEV_ADDR_HI 5'h13
// Upper five bits of the speed-up master code
`define HS_CODE_HI 5'h01
`define BYTE_BITS 4'h8
// Spike limits in ns, and the sampling clock period in ns
`define SPIKE_FS_NS 50
`define SPIKE_HS_NS 10
`define LINK_CLK_PERIOD_NS 12
// Cycles after reset before the select pins are frozen
`define STRAP_SETTLE 2'h3
`endif

// File: rtl/twowire_slave_pkg.sv
`default_nettype none
package twowire_slave_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WRITE,
    ST_WRITE_ACK,
    ST_READ,
    ST_READ_ACK,
    ST_IGNORE
  } link_state_t;

  typedef struct packed {
    logic level;
    logic [2:0] cnt;
  } filt_state_t;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] hi_s;
    logic [1:0] lo_s;
    logic scl_p;
    logic sda_p;
    logic [1:0] strap_cnt;
    logic [1:0] sel;
    link_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] last;
    logic hs;
    logic oe;
    logic rw;
    logic acked;
    logic first;
    logic [8:0] word;
    logic tog;
    logic act;
  } link_regs_t;

  typedef struct packed {
    logic [2:0] tog_s;
    logic [3:0] act_s;
    logic [7:0] code;
    logic valid;
    logic first;
  } core_regs_t;
endpackage : twowire_slave_pkg
`default_nettype wire

// File: tb/twowire_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Bus master model; lines move just after bus_clk edges
module twowire_master_model (
  input wire logic bus_clk,
  input wire logic sda_in,
  output logic scl_low,
  output logic sda_low
);
  // Half bit in bus_clk cycles: 10 normal, 5 high-speed
  int hp = 10;
  logic spk = 1'b0;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge bus_clk);
    #1;
  endtask : w
  // Also serves as repeated start; hp cycles of hold after scl falls
  task automatic start();
    w(1);
    sda_low = 1'b0;
    w(hp);
    scl_low = 1'b0;
    w(hp);
    sda_low = 1'b1;
    w(hp);
    scl_low = 1'b1;
    w(hp);
  endtask : start
  task automatic bit_io(input logic b, output logic r);
    w(1);
    sda_low = ~b;
    if (spk) begin
      w(2);
      scl_low = 1'b0;
      w(2);
      scl_low = 1'b1;
      spk = 1'b0;
    end
    w(hp);
    scl_low = 1'b0;
    w(hp / 2);
    r = sda_in;
    w(hp - hp / 2);
    scl_low = 1'b1;
  endtask : bit_io
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : put
  task automatic get(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask : get
  task automatic stop();
    w(1);
    sda_low = 1'b1;
    w(hp);
    scl_low = 1'b0;
    w(hp);
    sda_low = 1'b0;
    w(hp);
  endtask : stop
endmodule : twowire_master_model
`default_nettype wire

// File: tb/tb_quad_dac_twowire_slave_port.sv
`timescale 1ns/1ps
`include "twowire_slave_map.svh"
`default_nettype none
// ====================
// Bench: master model on the wire, byte checks on the core side
module tb_quad_dac_twowire_slave_port;
  logic core_clk = 1'b0;
  logic bus_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hi_pin, lo_pin, scl_low, sda_low, scl_w, sda_w, ack;
  logic sda_o, sda_oe, rx_valid, rx_first, link_active, hs_mode;
  logic [7:0] rx_code, last;
  logic [6:0] own, a;
  logic [7:0] exp_q[$], got_q[$];
  logic fexp_q[$], fgot_q[$];
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 32'h9401;
  // Open drain with pull-ups: any party pulling low wins
  assign scl_w = ~scl_low;
  assign sda_w = ~(sda_low | sda_oe);
  initial forever #5 core_clk = ~core_clk;
  initial begin
    #2.3;
    forever #6 bus_clk = ~bus_clk;
  end
  quad_dac_twowire_slave_port DUT (.core_clk(core_clk), .rst_b(rst_b),
    .bus_clk(bus_clk), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .address_select_hi_pin(hi_pin),
    .address_select_lo_pin(lo_pin), .rx_code(rx_code),
    .rx_valid(rx_valid), .rx_first(rx_first),
    .link_active(link_active), .hs_mode(hs_mode));
  twowire_master_model m (.bus_clk(bus_clk), .sda_in(sda_w),
    .scl_low(scl_low), .sda_low(sda_low));
  always @(posedge core_clk) begin
    if (rx_valid === 1'b1) begin
      got_q.push_back(rx_code);
      fgot_q.push_back(rx_first);
    end
  end
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  // Only the own address is answered; general call and others never
  function automatic logic want_ack(input logic [6:0] ad);
    return ad == {`DEV_ADDR_HI, hi_pin, lo_pin};
  endfunction : want_ack
  // First two written bytes are the code extremes, the rest random
  task automatic frame(input logic [6:0] ad, input logic rw, input int n,
                       input logic ex);
    logic k;
    logic [7:0] d;
    m.start();
    m.put({ad, rw}, k);
    chk("addr_ack", 8'(want_ack(ad)), 8'(k));
    for (int i = 0; i < n && ex; i++) begin
      if (rw) begin
        m.get(i == n - 1, d);
        chk("read_data", last, d);
      end else begin
        d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
        m.put(d, k);
        chk("data_ack", 8'h01, 8'(k));
        exp_q.push_back(d);
        fexp_q.push_back(i == 0);
        last = d;
      end
    end
    // A refused read byte drops the link; let the synchroniser catch up
    if (ex) begin
      m.w(12);
      chk("link_active", 8'(!rw), 8'(link_active));
    end
  endtask : frame
  task automatic end_frame();
    m.stop();
    m.w(30);
    chk("link_idle", 8'h00, 8'(link_active));
    chk("rx_count", 8'(exp_q.size()), 8'(got_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0) begin
      chk("rx_code", exp_q.pop_front(), got_q.pop_front());
      chk("rx_first", 8'(fexp_q.pop_front()),
          8'(fgot_q.pop_front()));
    end
    exp_q.delete();
    got_q.delete();
    fexp_q.delete();
    fgot_q.delete();
  endtask : end_frame
  initial begin
    {hi_pin, lo_pin} = 2'($random(seed));
    own = {`DEV_ADDR_HI, hi_pin, lo_pin};
    repeat (5) @(posedge core_clk);
    #1 rst_b = 1'b1;
    chk("sda_oe", 8'h00, 8'(sda_oe));
    chk("rx_valid", 8'h00, 8'(rx_valid));
    m.w(20);
    frame(own, 1'b0, 5, 1'b1);
    end_frame();
    frame(own, 1'b1, 3, 1'b1);
    end_frame();
    frame(7'h00, 1'b0, 0, 1'b0);
    end_frame();
    do a = 7'($random(seed)); while (a == own);
    frame(a, 1'b0, 0, 1'b0);
    end_frame();
    // Own address clocked with no start must be ignored
    m.put({own, 1'b0}, ack);
    chk("nostart_ack", 8'h00, 8'(ack));
    end_frame();
    // Short scl spike inside the address byte must vanish
    m.spk = 1'b1;
    frame(own, 1'b0, 2, 1'b1);
    end_frame();
    m.start();
    m.put({`HS_CODE_HI, 3'($random(seed))}, ack);
    chk("code_ack", 8'h00, 8'(ack));
    m.w(10);
    chk("hs_on", 8'h01, 8'(hs_mode));
    m.hp = 5;
    frame(own, 1'b0, 3, 1'b1);
    end_frame();
    chk("hs_off", 8'h00, 8'(hs_mode));
    chk("sda_o", 8'h00, 8'(sda_o));
    close_out();
  end
  // Whole run needs well under 150 us
  initial begin
    #400000;
    n_errors++;
    close_out();
  end
endmodule : tb_quad_dac_twowire_slave_port
`default_nettype wire
